/* msrf_pkg.sv */
// Shared constants and types of the meter serial report framer.
package msrf_pkg;

    // **********************************************
    // Timing
    // **********************************************
    localparam int CLK_HZ = 125000000;
    localparam int BAUD_RATE = 19230;
    // Cycles per serial bit; the rate error against the nominal baud is far below a percent.
    localparam int BIT_CYCLES_DFLT = CLK_HZ / BAUD_RATE;
    localparam logic [3:0] FRAME_LAST_BIT = 4'h9;

    // **********************************************
    // Block layout and character codes
    // **********************************************
    localparam logic [3:0] IDX_RANGE = 4'h0;
    localparam logic [3:0] IDX_D3 = 4'h1;
    localparam logic [3:0] IDX_D2 = 4'h2;
    localparam logic [3:0] IDX_D1 = 4'h3;
    localparam logic [3:0] IDX_D0 = 4'h4;
    localparam logic [3:0] IDX_FUNC = 4'h5;
    localparam logic [3:0] IDX_STAT = 4'h6;
    localparam logic [3:0] IDX_OPT1 = 4'h7;
    localparam logic [3:0] IDX_OPT2 = 4'h8;
    localparam logic [3:0] IDX_CR = 4'h9;
    localparam logic [3:0] IDX_LF = 4'ha;
    localparam logic [2:0] FIELD_HI = 3'h3;
    localparam logic [6:0] DIGIT_BASE = 7'h30;
    localparam logic [6:0] RANGE_BASE = 7'h30;
    localparam logic [6:0] FIXED_RANGE = 7'h30;
    localparam logic [6:0] CODE_CR = 7'h0d;
    localparam logic [6:0] CODE_LF = 7'h0a;
    localparam logic [15:0] OVL_DIGITS = 16'h4000;
    localparam logic [6:0] FC_VOLT = 7'h3b;
    localparam logic [6:0] FC_UA = 7'h3d;
    localparam logic [6:0] FC_MA = 7'h3f;
    localparam logic [6:0] FC_AUTO_A = 7'h30;
    localparam logic [6:0] FC_MAN_A = 7'h39;
    localparam logic [6:0] FC_OHM = 7'h33;
    localparam logic [6:0] FC_CONT = 7'h35;
    localparam logic [6:0] FC_DIODE = 7'h31;
    localparam logic [6:0] FC_TEMP = 7'h34;
    localparam logic [6:0] FC_ADAPTER_MODE_0 = 7'h3e;
    localparam logic [6:0] FC_ADAPTER_MODE_1 = 7'h3c;
    localparam logic [6:0] FC_ADAPTER_MODE_2 = 7'h38;
    localparam logic [6:0] FC_ADAPTER_MODE_3 = 7'h3a;

    // Measurement function as software selects it.
    typedef enum logic [3:0] {
        FN_VOLT, FN_UA, FN_MA, FN_AUTO_A, FN_MAN_A, FN_OHM, FN_CONT,
        FN_DIODE, FN_TEMP, FN_ADAPTER_MODE_0, FN_ADAPTER_MODE_1, FN_ADAPTER_MODE_2, FN_ADAPTER_MODE_3
    } msrf_func_e;

    // **********************************************
    // Register map
    // **********************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MEAS = 8'h04;
    localparam logic [7:0] ADDR_DIGITS = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_TRIG_BIT = 1;
    localparam int MEAS_FUNC_LSB = 0;
    localparam int MEAS_RANGE_LSB = 4;
    localparam int MEAS_FLAGS_LSB = 8;
    localparam int FLG_AUTO = 0;
    localparam int FLG_AC = 1;
    localparam int FLG_DC = 2;
    localparam int FLG_HOLD = 3;
    localparam int FLG_OVF = 4;
    localparam int FLG_BATTERY_LOW_FLAG = 5;
    localparam int FLG_MINUS = 6;
    localparam int FLG_TEMPC = 7;
    localparam logic RST_ENABLE = 1'b0;
    localparam logic [3:0] RST_FUNC = 4'h0;
    localparam logic [2:0] RST_RANGE = 3'h0;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [15:0] RST_DIGITS = 16'h0000;

endpackage

/* msrf_char_if.sv */
// Character hand-off between the block sequencer and the frame serialiser.
`timescale 1ns/10ps
`default_nettype none
interface msrf_char_if;
    logic valid;
    logic ready;
    logic [6:0] code;
    modport src (output valid, output code, input ready);
    modport snk (input valid, input code, output ready);
endinterface // msrf_char_if
`default_nettype wire

/* msrf_code_map.sv */
// Maps the selected function and range onto their report characters.
`timescale 1ns/10ps
`default_nettype none
module msrf_code_map
    import msrf_pkg::*;
(
    input wire msrf_pkg::msrf_func_e func_in, // Selected function.
    input wire logic [2:0] range_in, // Range index.
    output logic [6:0] func_code_out, // Function character.
    output logic [6:0] range_code_out // Range character.
);
    import msrf_pkg::*;

    // The report encoding differs from the mode-select input encoding.
    always_comb begin
        case (func_in)
            FN_VOLT: func_code_out = FC_VOLT; // see [R10]
            FN_UA: func_code_out = FC_UA; // see [R10]
            FN_MA: func_code_out = FC_MA;
            FN_AUTO_A: func_code_out = FC_AUTO_A;
            FN_MAN_A: func_code_out = FC_MAN_A;
            FN_OHM: func_code_out = FC_OHM; // see [R11]
            FN_CONT: func_code_out = FC_CONT;
            FN_DIODE: func_code_out = FC_DIODE;
            FN_TEMP: func_code_out = FC_TEMP;
            FN_ADAPTER_MODE_0: func_code_out = FC_ADAPTER_MODE_0; // see [R11]
            FN_ADAPTER_MODE_1: func_code_out = FC_ADAPTER_MODE_1;
            FN_ADAPTER_MODE_2: func_code_out = FC_ADAPTER_MODE_2;
            FN_ADAPTER_MODE_3: func_code_out = FC_ADAPTER_MODE_3;
            default: func_code_out = FC_VOLT;
        endcase
    end

    // Single full-scale modes report the first range whatever software left in the field.
    always_comb begin
        case (func_in)
            FN_CONT, FN_DIODE, FN_MAN_A: range_code_out = FIXED_RANGE; // see [R12]
            default: range_code_out = RANGE_BASE | {4'h0, range_in}; // see [R13]
        endcase
    end

endmodule // msrf_code_map
`default_nettype wire

/* msrf_frame_tx.sv */
// Serialiser that sends one character as start, seven data, odd parity and stop bit.
`timescale 1ns/10ps
`default_nettype none
module msrf_frame_tx
    import msrf_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DFLT
) (
    input wire logic clock_in, // System clock.
    input wire logic rstn_in, // Synchronous reset, active low.
    msrf_char_if.snk ch, // Character to send.
    output logic line_out // Serial line, from a flop.
);
    import msrf_pkg::*;

    typedef enum logic {TX_IDLE, TX_SHIFT} msrf_tx_e;
    typedef struct packed {
        msrf_tx_e st;
        logic [9:0] sh;
        logic [15:0] cnt;
        logic [3:0] nbit;
        logic line;
    } msrf_tx_s;

    msrf_tx_s r, n;

    assign ch.ready = (r.st == TX_IDLE);
    assign line_out = r.line;

    // **********************************************
    // Bit timing and shifting
    // **********************************************
    // The frame is loaded whole so that parity is fixed before the first bit leaves.
    always_comb begin
        n = r;
        case (r.st)
            TX_IDLE: begin
                n.line = 1'b1; // see [R04]
                if (ch.valid) begin
                    n.sh = {1'b1, ~^ch.code, ch.code, 1'b0}; // see [R03]
                    n.st = TX_SHIFT;
                    n.cnt = 16'h0000;
                    n.nbit = 4'h0;
                    n.line = 1'b0;
                end
            end
            TX_SHIFT: begin
                n.cnt = 16'(r.cnt + 16'h0001);
                if (r.cnt == 16'(BIT_CYCLES - 1)) begin // see [R02]
                    n.cnt = 16'h0000;
                    n.nbit = 4'(r.nbit + 4'h1);
                    n.sh = {1'b1, r.sh[9:1]}; // see [R06]
                    n.line = r.sh[1];
                    if (r.nbit == FRAME_LAST_BIT) begin
                        n.st = TX_IDLE;
                        n.line = 1'b1;
                    end
                end
            end
            default: n.st = TX_IDLE;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            r <= '{st: TX_IDLE, sh: 10'h3ff, cnt: 16'h0000, nbit: 4'h0, line: 1'b1};
        end else begin
            r <= n;
        end
    end

    // **********************************************
    // Checks
    // **********************************************
    a_idle_line_high: assert property (@(posedge clock_in) disable iff (!rstn_in) // see [R04]
        (r.st == TX_IDLE && !$past(ch.valid)) |-> line_out)
        else $error("line not high while idle");
    a_start_bit_low: assert property (@(posedge clock_in) disable iff (!rstn_in) // see [R03]
        (r.st == TX_IDLE && ch.valid) |=> (!line_out && r.st == TX_SHIFT))
        else $error("start bit not low");
    a_stop_bit_high: assert property (@(posedge clock_in) disable iff (!rstn_in) // see [R03]
        (r.st == TX_SHIFT && r.nbit == FRAME_LAST_BIT) |-> line_out)
        else $error("stop bit not high");
    a_bit_period: assert property (@(posedge clock_in) disable iff (!rstn_in) // see [R02]
        (r.st == TX_SHIFT && r.cnt == 16'h0000 && $past(r.st) == TX_SHIFT) |->
        $past(r.cnt) == 16'(BIT_CYCLES - 1))
        else $error("bit period wrong");

endmodule // msrf_frame_tx
`default_nettype wire

/* msrf_top.sv */
// Report framer top: APB registers, block sequencing and character assembly.
// What this block does
// [R01] Send the whole report block twice for each conversion cycle.
// [R02] Characters hold seven bit codes sent at 19230 bits per second.
// [R03] Frame is start 0, seven data bits, odd parity, stop 1.
// [R04] Line rests high whenever no frame is being sent.
// [R05] Host may start sampling on the falling edge of the start bit.
// [R06] Data bits leave least significant first.
// [R07] A block holds eleven characters ending in carriage return and line feed.
// [R08] Order: range, digits 3 to 0, function, status, options, CR, LF.
// [R09] Digits always carry the live value, even while hold freezes the panel.
// [R10] Function codes for voltage and the four current modes.
// [R11] Function codes for resistance, continuity, diode, temperature, adapter modes.
// [R12] Continuity, diode and fixed amp modes always report the first range.
// [R13] Range codes count upward from the first full scale.
// [R14] Digits go most significant first, each as 0x30 plus the digit.
// [R15] Overload sends the digits 4000.
// [R16] Status: 011, temperature unit, minus, battery low, overflow.
// [R17] Unit flag is 1 for Celsius, meaningful only in temperature mode.
// [R18] Option 1: 011, hold, then three zeros.
// [R19] Option 2: 011, DC, AC, auto ranging, then zero.
// [R20] Delimiters are carriage return 0001101 then line feed 0001010.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module msrf_top
    import msrf_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DFLT
) (
    input wire logic clock_in, // System clock, 125 MHz.
    input wire logic rstn_in, // Synchronous reset, active low.
    input wire logic [7:0] paddr_in, // APB byte address.
    input wire logic psel_in, // APB select.
    input wire logic penable_in, // APB enable.
    input wire logic pwrite_in, // APB write.
    input wire logic [31:0] pwdata_in, // APB write data.
    output logic [31:0] prdata_out, // APB read data.
    output logic pready_out, // APB ready.
    output logic pslverr_out, // APB error for unmapped addresses.
    input wire logic conv_tick_in, // One pulse per conversion cycle.
    output logic serial_report_out // Serial report line.
);
    import msrf_pkg::*;

    typedef enum logic {SQ_IDLE, SQ_SEND} msrf_seq_e;
    typedef struct packed {
        // Software registers.
        logic enable;
        logic [3:0] func;
        logic [2:0] range;
        logic [7:0] flags;
        logic [15:0] digits;
        // Snapshot taken when a block starts.
        logic [3:0] s_func;
        logic [2:0] s_range;
        logic [7:0] s_flags;
        logic [15:0] s_digits;
        // Sequencer position.
        logic pending;
        msrf_seq_e seq;
        logic [3:0] idx;
        logic rep;
        logic [7:0] blocks;
        // Registered bus answer.
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } msrf_top_s;

    msrf_top_s r, n;
    msrf_char_if ch ();
    logic [6:0] func_code;
    logic [6:0] range_code;
    logic [15:0] dsel;
    logic setup;
    logic wr_take;
    logic accept;
    logic trig_wr;

    // Builds a character from the fixed 011 prefix and a four bit field.
    function automatic logic [6:0] fld(input logic [3:0] v);
        return {FIELD_HI, v};
    endfunction

    // Turns one decimal digit into its character.
    function automatic logic [6:0] dig(input logic [3:0] d);
        return DIGIT_BASE | {3'h0, d}; // see [R14]
    endfunction

    // Unmapped addresses, including unaligned ones, answer with an error.
    function automatic logic mapped(input logic [7:0] a);
        return (a == ADDR_CTRL) ||
               (a == ADDR_MEAS) ||
               (a == ADDR_DIGITS) ||
               (a == ADDR_STAT);
    endfunction

    // **********************************************
    // Character assembly
    // **********************************************
    msrf_code_map u_map (
        .func_in(msrf_func_e'(r.s_func)),
        .range_in(r.s_range),
        .func_code_out(func_code),
        .range_code_out(range_code)
    );

    // Overload replaces the digits; hold has no say here, so the live value goes out.
    assign dsel = r.s_flags[FLG_OVF] ? OVL_DIGITS : r.s_digits; // see [R15] see [R09]
    assign ch.valid = (r.seq == SQ_SEND);
    assign accept = ch.valid && ch.ready;

    // Select the character for the current slot of the block.
    always_comb begin
        case (r.idx) // see [R08]
            IDX_RANGE: ch.code = range_code;
            IDX_D3: ch.code = dig(dsel[15:12]); // see [R14]
            IDX_D2: ch.code = dig(dsel[11:8]);
            IDX_D1: ch.code = dig(dsel[7:4]);
            IDX_D0: ch.code = dig(dsel[3:0]);
            IDX_FUNC: ch.code = func_code;
            IDX_STAT: ch.code = fld({r.s_flags[FLG_TEMPC], r.s_flags[FLG_MINUS],
                                     r.s_flags[FLG_BATTERY_LOW_FLAG], r.s_flags[FLG_OVF]}); // see [R16] see [R17]
            IDX_OPT1: ch.code = fld({r.s_flags[FLG_HOLD], 3'h0}); // see [R18]
            IDX_OPT2: ch.code = fld({r.s_flags[FLG_DC], r.s_flags[FLG_AC],
                                     r.s_flags[FLG_AUTO], 1'b0}); // see [R19]
            IDX_CR: ch.code = CODE_CR; // see [R20]
            IDX_LF: ch.code = CODE_LF; // see [R20]
            default: ch.code = CODE_LF;
        endcase
    end

    // The serialiser owns the line; its ready marks the character slot as free.
    msrf_frame_tx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_tx (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .ch(ch),
        .line_out(serial_report_out)
    );

    // **********************************************
    // Next state
    // **********************************************
    // Setup is the first cycle of a transfer; a write lands in the access cycle.
    assign setup = psel_in && !penable_in;
    assign wr_take = psel_in && penable_in && r.pready && pwrite_in;
    // A software trigger counts exactly like a conversion tick.
    assign trig_wr = wr_take && (paddr_in == ADDR_CTRL) && pwdata_in[CTRL_TRIG_BIT];

    // One process covers the bus slave and the sequencer so each field has one writer.
    always_comb begin
        n = r;
        // The answer is prepared in the setup cycle, so every access has no wait state.
        n.pready = setup;
        if (setup) begin
            n.pslverr = !mapped(paddr_in);
            case (paddr_in)
                ADDR_CTRL: n.prdata = {31'h0, r.enable};
                ADDR_MEAS: n.prdata = {16'h0, r.flags, 1'b0, r.range, r.func};
                ADDR_DIGITS: n.prdata = {16'h0, r.digits};
                ADDR_STAT: n.prdata = {16'h0, r.blocks, 1'b0, r.pending, r.idx, r.rep,
                                       (r.seq == SQ_SEND)};
                default: n.prdata = 32'h0;
            endcase
        end else begin
            n.pslverr = 1'b0;
            n.prdata = 32'h0;
        end
        // Register writes; the status word is read only and ignores writes.
        if (wr_take) begin
            case (paddr_in)
                ADDR_CTRL: n.enable = pwdata_in[CTRL_EN_BIT];
                ADDR_MEAS: begin
                    n.func = pwdata_in[MEAS_FUNC_LSB +: 4];
                    n.range = pwdata_in[MEAS_RANGE_LSB +: 3];
                    n.flags = pwdata_in[MEAS_FLAGS_LSB +: 8];
                end
                ADDR_DIGITS: n.digits = pwdata_in[15:0];
                default: n.func = r.func;
            endcase
        end
        // A tick that lands on the cycle that takes the request is kept for the next cycle.
        n.pending = r.pending || conv_tick_in || trig_wr;
        case (r.seq)
            SQ_IDLE: begin
                if (r.enable && r.pending) begin
                    // Snapshot once per cycle so both copies of the block agree.
                    n.s_func = r.func;
                    n.s_range = r.range;
                    n.s_flags = r.flags;
                    n.s_digits = r.digits;
                    n.seq = SQ_SEND;
                    n.idx = IDX_RANGE;
                    n.rep = 1'b0;
                    n.pending = conv_tick_in || trig_wr;
                end
            end
            SQ_SEND: begin
                if (accept) begin
                    n.idx = 4'(r.idx + 4'h1);
                    if (r.idx == IDX_LF) begin // see [R07]
                        n.idx = IDX_RANGE;
                        if (r.rep) begin
                            n.seq = SQ_IDLE;
                            n.blocks = 8'(r.blocks + 8'h01);
                        end else begin
                            n.rep = 1'b1; // see [R01]
                        end
                    end
                end
            end
            default: n.seq = SQ_IDLE;
        endcase
    end

    // **********************************************
    // State register
    // **********************************************
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            r <= '{enable: RST_ENABLE,
                   func: RST_FUNC,
                   range: RST_RANGE,
                   flags: RST_FLAGS,
                   digits: RST_DIGITS,
                   s_func: RST_FUNC,
                   s_range: RST_RANGE,
                   s_flags: RST_FLAGS,
                   s_digits: RST_DIGITS,
                   pending: 1'b0,
                   seq: SQ_IDLE,
                   idx: IDX_RANGE,
                   rep: 1'b0,
                   blocks: 8'h00,
                   prdata: 32'h0,
                   pready: 1'b0,
                   pslverr: 1'b0};
        end else begin
            r <= n;
        end
    end

    // Bus outputs come straight from the answer flops.
    assign prdata_out = r.prdata;
    assign pready_out = r.pready;
    assign pslverr_out = r.pslverr;

    // **********************************************
    // Checks
    // **********************************************
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rstn_in);

    // Sequencer and character checks first, then the bus answer.
    a_second_block: assert property ((accept && r.idx == IDX_LF && !r.rep) |=> // see [R01]
        (r.seq == SQ_SEND && r.idx == IDX_RANGE && r.rep))
        else $error("second copy of block not started");

    a_block_start: assert property ((r.seq == SQ_IDLE && r.enable && r.pending) |=> // see [R01]
        (r.seq == SQ_SEND && r.idx == IDX_RANGE && !r.rep))
        else $error("pending block not started");

    a_tick_kept: assert property ((r.seq == SQ_IDLE && r.enable && r.pending && // see [R01]
        (conv_tick_in || trig_wr)) |=> r.pending)
        else $error("request at block start lost");

    a_block_length: assert property ((r.seq == SQ_SEND) |-> (r.idx <= IDX_LF)) // see [R07]
        else $error("block longer than eleven characters");

    a_line_feed_last: assert property ((accept && r.idx == IDX_CR) |-> // see [R20]
        (ch.code == CODE_CR) ##1 (r.idx == IDX_LF && ch.code == CODE_LF))
        else $error("carriage return not followed by line feed");

    a_fixed_prefix: assert property ((accept && r.idx <= IDX_OPT2) |-> // see [R16]
        ch.code[6:4] == FIELD_HI)
        else $error("field character lacks 011 prefix");

    a_opt1_low_zero: assert property ((accept && r.idx == IDX_OPT1) |-> ch.code[2:0] == 3'h0) // see [R18]
        else $error("option 1 low bits not zero");

    a_overload_digits: assert property ((accept && r.idx == IDX_D3 && r.s_flags[FLG_OVF]) |-> // see [R15]
        ch.code == 7'h34)
        else $error("overload digits not 4000");

    a_fixed_range: assert property ((accept && r.idx == IDX_RANGE && // see [R12]
        (r.s_func == FN_CONT || r.s_func == FN_DIODE || r.s_func == FN_MAN_A)) |->
        ch.code == FIXED_RANGE)
        else $error("fixed mode range not first code");

    a_apb_answer: assert property (setup |=> (pready_out && pslverr_out == !mapped($past(paddr_in))))
        else $error("apb answer missing");

    // Scenarios to reach; the bench reaches all but c_tick_busy, as it sends no tick while a block is being sent.
    c_two_blocks: cover property (accept && r.idx == IDX_LF && r.rep);
    c_tick_busy: cover property (conv_tick_in && r.seq == SQ_SEND);
    c_overload: cover property (accept && r.idx == IDX_D0 && r.s_flags[FLG_OVF]);
    c_apb_error: cover property (pready_out && pslverr_out);
    c_fixed_range: cover property (accept && r.idx == IDX_RANGE && r.s_func == FN_DIODE);

endmodule // msrf_top
`default_nettype wire

/* msrf_blank_end.sv */
// Empty unit; intentionally holds no design.

/* msrf_host_rx.sv */
// Host side receiver model that decodes report characters from the serial line.
`timescale 1ns/10ps
`default_nettype none
module msrf_host_rx #(
    parameter int BIT_CYCLES = 8 // Clock cycles per serial bit.
) (
    input wire logic clock_in, // System clock.
    input wire logic rstn_in, // Synchronous reset, active low.
    input wire logic line_in // Serial report line.
);
    logic [6:0] codes [$];
    int frame_errs = 0;
    logic [7:0] sh;

    // Sampling mid-bit keeps the model tolerant of a one-cycle skew at the start edge.
    initial begin
        forever begin
            @(posedge clock_in);
            if (rstn_in === 1'b1 && line_in === 1'b0) begin // Low line starts a character.
                repeat (BIT_CYCLES / 2) @(posedge clock_in);
                if (line_in !== 1'b0) frame_errs++;
                // Seven data bits and then the parity bit; the stop bit is checked apart.
                for (int b = 0; b < 8; b++) begin
                    repeat (BIT_CYCLES) @(posedge clock_in);
                    sh[b] = line_in; // Data arrive least significant first.
                end
                repeat (BIT_CYCLES) @(posedge clock_in);
                if (line_in !== 1'b1 || ^sh !== 1'b1) frame_errs++; // Stop high, odd parity.
                codes.push_back(sh[6:0]);
            end
        end
    end
endmodule // msrf_host_rx
`default_nettype wire

/* msrf_top_tb.sv */
// Self-checking bench for the meter serial report framer.
`timescale 1ns/10ps
`default_nettype none
module msrf_top_tb;
    localparam int BITC = 8;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic conv_tick_in = 1'b0;
    logic serial_report_out;
    int num_errors = 0;
    int cmp_count = 0;
    logic [31:0] q;
    logic e;
    logic [15:0] meas;
    logic [15:0] dig;
    logic [6:0] fcode [13] = '{7'h3b, 7'h3d, 7'h3f, 7'h30, 7'h39, 7'h33, 7'h35, 7'h31, 7'h34, 7'h3e, 7'h3c,
                                7'h38, 7'h3a};

    // Clock at 125 MHz.
    always #4 clock_in = ~clock_in;

    msrf_top #(.BIT_CYCLES(BITC)) dut (.clock_in, .rstn_in, .paddr_in, .psel_in, .penable_in, .pwrite_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .conv_tick_in, .serial_report_out);
    msrf_host_rx #(.BIT_CYCLES(BITC)) host (.clock_in, .rstn_in, .line_in(serial_report_out));

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic err);
        int n;
        n = 0;
        @(posedge clock_in);
        psel_in <= 1'b1;
        paddr_in <= a;
        pwrite_in <= w;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clock_in);
            n++;
            if (n > 20) begin
                num_errors++;
                wrap_up();
            end
        end while (pready_out !== 1'b1);
        r = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    // Expected character k of a block, from the measurement and digit words.
    function automatic logic [6:0] exp_char(input int k);
        logic [15:0] d;
        logic [7:0] fl;
        fl = meas[15:8];
        d = fl[4] ? 16'h4000 : dig;
        case (k)
            0: exp_char = (meas[3:0] inside {4'h4, 4'h6, 4'h7}) ? 7'h30 : 7'h30 + 7'(meas[6:4]);
            1, 2, 3, 4: exp_char = 7'h30 | 7'(d[(4 - k) * 4 +: 4]);
            5: exp_char = fcode[meas[3:0]];
            6: exp_char = {3'h3, fl[7:4]};
            7: exp_char = {3'h3, fl[3], 3'h0};
            8: exp_char = {3'h3, fl[2:0], 1'b0};
            9: exp_char = 7'h0d;
            default: exp_char = 7'h0a;
        endcase
    endfunction

    // Main sequence: reset values, a held trigger, then random blocks with corner cases.
    initial begin
        void'($urandom(32'hd03252bb));
        repeat (6) @(posedge clock_in);
        rstn_in <= 1'b1;
        for (int a = 0; a < 5; a++) begin
            apb(1'b0, 8'(a * 4), 32'h0, q, e);
            chk("prdata", 32'h0, q);
            chk("pslverr", {31'h0, a == 4}, {31'h0, e});
        end
        @(posedge clock_in);
        conv_tick_in <= 1'b1;
        @(posedge clock_in);
        conv_tick_in <= 1'b0;
        repeat (300) @(posedge clock_in);
        chk("chars", 32'h0, 32'(host.codes.size()));
        chk("line", 32'h1, {31'h0, serial_report_out});
        $display("test disabled trigger done");
        for (int i = 0; i < 15; i++) begin
            meas = {8'($urandom), 1'b0, 3'($urandom_range(7)), 4'(i < 13 ? i : $urandom_range(12))};
            dig = {4'($urandom_range(9)), 4'($urandom_range(9)), 4'($urandom_range(9)), 4'($urandom_range(9))};
            if (i == 0) begin
                meas[15:8] = 8'h00;
                dig = 16'h9999;
            end
            if (i == 14) meas[12] = 1'b1;
            apb(1'b1, 8'h04, {16'h0, meas}, q, e);
            apb(1'b1, 8'h08, {16'h0, dig}, q, e);
            apb(1'b0, 8'h04, 32'h0, q, e);
            chk("meas", {16'h0, meas}, q);
            // The first block comes from the trigger held while disabled.
            if (i == 0) apb(1'b1, 8'h00, 32'h1, q, e);
            else if (i % 2 == 1) begin
                @(posedge clock_in);
                conv_tick_in <= 1'b1;
                @(posedge clock_in);
                conv_tick_in <= 1'b0;
            end
            else apb(1'b1, 8'h00, 32'h3, q, e);
            for (int n = 0; host.codes.size() < 22; n++) begin
                if (n > 4000) begin
                    num_errors++;
                    wrap_up();
                end
                @(posedge clock_in);
            end
            repeat (200) @(posedge clock_in);
            chk("chars", 32'd22, 32'(host.codes.size()));
            chk("line", 32'h1, {31'h0, serial_report_out});
            chk("frame errors", 32'h0, 32'(host.frame_errs));
            for (int k = 0; k < 22; k++) chk("char", {25'h0, exp_char(k % 11)}, {25'h0, host.codes[k]});
            host.codes.delete();
            apb(1'b0, 8'h0c, 32'h0, q, e);
            chk("blocks", 32'(i + 1), {24'h0, q[15:8]});
            chk("busy", 32'h0, {31'h0, q[0]});
            $display("test block %0d done", i);
        end
        wrap_up();
    end
endmodule // msrf_top_tb
`default_nettype wire
